// ===== rtl/tap_cfg.svh
// Constants of the boundary-scan test access port
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH

// Instruction register
`define IR_LEN 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE 3'h2
`define IR_CLAMP 3'h3
`define IR_HIGHZ 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE_VAL 3'h1

// Identification register layout
`define ID_LEN 32
`define ID_MARK_BIT 1'h1
`define ID_MANUF_W 11
`define ID_PART_W 16
`define ID_VER_W 4

// Mode select edges that always reach the reset state
`define TMS_RESET_EDGES 5

`endif

// ===== rtl/tap_pkg.sv
// Types shared by the boundary-scan test access port
`default_nettype none
package tap_pkg;

  // Controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  // Data register in the serial path
  typedef enum logic [1:0] {DR_BSR, DR_BYPASS, DR_ID} dr_sel_t;

  // Pad control handed to the system side
  typedef struct packed {
    logic drive_bsr;
    logic force_hiz;
  } pad_mode_t;

endpackage
`default_nettype wire

// ===== rtl/sync2.sv
// Two flip-flop synchroniser for independent level bits
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,          // Destination clock
  input wire logic rst_n,        // Synchronous reset, active low
  input wire logic [W-1:0] d,    // Level from another domain
  output logic [W-1:0] q         // Level safe for the destination
);

  logic [W-1:0] meta_reg;

  // Only the second stage is read outside this module
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/tap_top.sv
// Boundary-scan test access port with controller, registers and pad control
// What this block does
// - Controller advances on test clock rising edge, steered by mode select.
// - Released test reset starts in Test-Logic-Reset with IDCODE, pads normal.
// - Select-DR-Scan holds registers; low goes Capture-DR, high Select-IR-Scan.
// - Capture-DR parallel-loads the selected register where it supports it.
// - Capture-DR goes to Shift-DR on low, Exit1-DR on high.
// - Shift-DR shifts selected register one stage per edge; others hold.
// - Exit1-DR goes to Update-DR on high, Pause-DR on low.
// - Pause-DR holds registers, stays on low, goes Exit2-DR on high.
// - Exit2-DR goes to Update-DR on high, back to Shift-DR on low.
// - Update-DR falling edge copies shift path into output latches.
// - Both update states go Run-Test-Idle on low, Select-DR-Scan on high.
// - Select-IR-Scan holds; low goes Capture-IR, high Test-Logic-Reset.
// - Capture-IR loads a fixed value; high goes Exit1-IR, low Shift-IR.
// - Shift-IR shifts instruction stage; latched instruction and data hold.
// - Shift-IR high goes Exit1-IR; Exit1-IR low Pause-IR, high Update-IR.
// - Pause-IR halts shifting, stays on low, goes Exit2-IR on high.
// - Exit2-IR goes Update-IR on high, back to Shift-IR on low.
// - Falling edge in Update-IR latches the new current instruction.
// - Codes 010 and 000 select the boundary-scan register.
// - Codes 111, 011 and 100 select the bypass register.
// - Code 001 selects the identification register.
// - Identification is 32 bits, LSB one, loaded on Capture-DR.
// - Bypass is a single stage between serial in and serial out.
// - HIGHZ floats outputs; CLAMP drives them steadily from boundary latches.
// - EXTEST drives outputs from latches and captures all inputs.
`include "tap_cfg.svh"
`default_nettype none
module tap_top #(
  parameter int N_IN = 4,                          // Input pad cells
  parameter int N_OUT = 4,                         // Output pad cells
  parameter logic [`ID_MANUF_W-1:0] MANUF_ID = 11'h0a5, // Arbitrary value
  parameter logic [`ID_PART_W-1:0] PART_ID = 16'h1234,  // Arbitrary value
  parameter logic [`ID_VER_W-1:0] VERSION_ID = 4'h1     // Arbitrary value
) (
  input wire logic SYS_CLK,                  // System clock, 250 MHz
  input wire logic RST_N,                    // System reset, active low
  input wire logic TEST_CLOCK_IN,            // Test clock from tester
  input wire logic TEST_RESET_N,             // Test reset, async, low
  input wire logic TEST_MODE_SELECT,         // Mode select
  input wire logic TEST_SERIAL_IN,           // Serial data in
  output logic TEST_SERIAL_OUT,              // Serial data out
  output logic TEST_SERIAL_OUT_OE,           // High while data out driven
  input wire logic [N_OUT-1:0] CORE_OUT,     // Framer output data
  input wire logic [N_OUT-1:0] CORE_OE,      // Framer output enables
  input wire logic [N_IN-1:0] PAD_IN,        // Input pad levels
  output logic [N_OUT-1:0] PAD_OUT,          // Output pad data
  output logic [N_OUT-1:0] PAD_OE            // Output pad enables
);

  localparam int BSR_LEN = N_IN + 2 * N_OUT;
  localparam int LAT_LEN = 2 * N_OUT;

  // Test clock domain
  tap_pkg::tap_state_t state_reg;
  tap_pkg::tap_state_t state_next;
  tap_pkg::dr_sel_t dr_sel;
  tap_pkg::pad_mode_t mode_now;
  tap_pkg::pad_mode_t mode_reg;
  logic [`IR_LEN-1:0] ir_shift_reg;
  logic [`IR_LEN-1:0] ir_latch_reg;
  logic bypass_reg;
  logic [`ID_LEN-1:0] id_shift_reg;
  logic [`ID_LEN-1:0] id_value;
  logic [BSR_LEN-1:0] bsr_shift_reg;
  logic [BSR_LEN-1:0] bsr_capture;
  logic [LAT_LEN-1:0] bsr_latch_reg;
  logic latch_toggle_reg;
  logic tdo_bit;
  logic in_shift;

  // System clock domain
  tap_pkg::pad_mode_t sys_mode;
  logic sys_toggle;
  logic sys_toggle_prev_reg;
  logic [LAT_LEN-1:0] sys_latch_reg;

  assign id_value = {VERSION_ID, PART_ID, MANUF_ID, `ID_MARK_BIT};

  // Controller state, held in reset by the test reset pin
  always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      state_reg <= tap_pkg::TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Next state from the mode select level
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tap_pkg::TLR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::TLR : tap_pkg::RTI;
      end
      tap_pkg::RTI: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::SEL_DR : tap_pkg::RTI;
      end
      tap_pkg::SEL_DR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      end
      tap_pkg::CAP_DR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      end
      tap_pkg::SHIFT_DR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::EXIT1_DR : tap_pkg::SHIFT_DR;
      end
      tap_pkg::EXIT1_DR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::UPD_DR : tap_pkg::PAUSE_DR;
      end
      tap_pkg::PAUSE_DR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::EXIT2_DR : tap_pkg::PAUSE_DR;
      end
      tap_pkg::EXIT2_DR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::UPD_DR : tap_pkg::SHIFT_DR;
      end
      tap_pkg::UPD_DR, tap_pkg::UPD_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::SEL_DR : tap_pkg::RTI;
      end
      tap_pkg::SEL_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::TLR : tap_pkg::CAP_IR;
      end
      tap_pkg::CAP_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      end
      tap_pkg::SHIFT_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::EXIT1_IR : tap_pkg::SHIFT_IR;
      end
      tap_pkg::EXIT1_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::UPD_IR : tap_pkg::PAUSE_IR;
      end
      tap_pkg::PAUSE_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::EXIT2_IR : tap_pkg::PAUSE_IR;
      end
      tap_pkg::EXIT2_IR: begin
        state_next = TEST_MODE_SELECT ? tap_pkg::UPD_IR : tap_pkg::SHIFT_IR;
      end
      default: begin
        state_next = tap_pkg::TLR;
      end
    endcase
  end

  // Instruction shift stage; holds outside capture and shift
  always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      ir_shift_reg <= `IR_CAPTURE_VAL;
    end else if (state_reg == tap_pkg::CAP_IR) begin
      ir_shift_reg <= `IR_CAPTURE_VAL;
    end else if (state_reg == tap_pkg::SHIFT_IR) begin
      ir_shift_reg <= {TEST_SERIAL_IN, ir_shift_reg[`IR_LEN-1:1]};
    end
  end

  // Current instruction changes only on a falling edge, never mid-shift
  always_ff @(negedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      ir_latch_reg <= `IR_IDCODE;
    end else if (state_reg == tap_pkg::TLR) begin
      ir_latch_reg <= `IR_IDCODE;
    end else if (state_reg == tap_pkg::UPD_IR) begin
      ir_latch_reg <= ir_shift_reg;
    end
  end

  // Instruction decode; spare codes fall to bypass
  always_comb begin
    case (ir_latch_reg)
      `IR_EXTEST, `IR_SAMPLE: dr_sel = tap_pkg::DR_BSR;
      `IR_IDCODE: dr_sel = tap_pkg::DR_ID;
      default: dr_sel = tap_pkg::DR_BYPASS;
    endcase
  end

  // Pad mode from the current instruction
  always_comb begin
    mode_now.drive_bsr = (ir_latch_reg == `IR_EXTEST) ||
                         (ir_latch_reg == `IR_CLAMP);
    mode_now.force_hiz = (ir_latch_reg == `IR_HIGHZ);
  end

  // Registered so that only a flop feeds the system-side synchroniser
  always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      mode_reg <= '0;
    end else begin
      mode_reg <= mode_now;
    end
  end

  // Bypass stage: zero on capture, one-bit path while shifting
  always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      bypass_reg <= 1'h0;
    end else if (dr_sel == tap_pkg::DR_BYPASS) begin
      if (state_reg == tap_pkg::CAP_DR) begin
        bypass_reg <= 1'h0;
      end else if (state_reg == tap_pkg::SHIFT_DR) begin
        bypass_reg <= TEST_SERIAL_IN;
      end
    end
  end

  // Identification shift register
  always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      id_shift_reg <= '0;
    end else if (dr_sel == tap_pkg::DR_ID) begin
      if (state_reg == tap_pkg::CAP_DR) begin
        id_shift_reg <= id_value;
      end else if (state_reg == tap_pkg::SHIFT_DR) begin
        id_shift_reg <= {TEST_SERIAL_IN, id_shift_reg[`ID_LEN-1:1]};
      end
    end
  end

  // Pins and core outputs come from other domains, so sync before capture
  sync2 #(.W(BSR_LEN)) u_capture_sync (
    .clk(TEST_CLOCK_IN),
    .rst_n(TEST_RESET_N),
    .d({CORE_OE, CORE_OUT, PAD_IN}),
    .q(bsr_capture)
  );

  // Boundary-scan shift path: inputs low, then output data, then enables
  always_ff @(posedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      bsr_shift_reg <= '0;
    end else if (dr_sel == tap_pkg::DR_BSR) begin
      if (state_reg == tap_pkg::CAP_DR) begin
        bsr_shift_reg <= bsr_capture;
      end else if (state_reg == tap_pkg::SHIFT_DR) begin
        bsr_shift_reg <= {TEST_SERIAL_IN, bsr_shift_reg[BSR_LEN-1:1]};
      end
    end
  end

  // Output latches move only in Update-DR, so CLAMP holds them steady
  always_ff @(negedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      bsr_latch_reg <= '0;
      latch_toggle_reg <= 1'h0;
    end else if (state_reg == tap_pkg::UPD_DR &&
                 dr_sel == tap_pkg::DR_BSR) begin
      bsr_latch_reg <= bsr_shift_reg[BSR_LEN-1:N_IN];
      latch_toggle_reg <= ~latch_toggle_reg;
    end
  end

  // Serial out mux
  always_comb begin
    in_shift = (state_reg == tap_pkg::SHIFT_DR) ||
               (state_reg == tap_pkg::SHIFT_IR);
    if (state_reg == tap_pkg::SHIFT_IR) begin
      tdo_bit = ir_shift_reg[0];
    end else begin
      case (dr_sel)
        tap_pkg::DR_BSR: tdo_bit = bsr_shift_reg[0];
        tap_pkg::DR_ID: tdo_bit = id_shift_reg[0];
        default: tdo_bit = bypass_reg;
      endcase
    end
  end

  // Falling-edge launch gives the tester half a period of setup
  always_ff @(negedge TEST_CLOCK_IN or negedge TEST_RESET_N) begin
    if (!TEST_RESET_N) begin
      TEST_SERIAL_OUT <= 1'h0;
      TEST_SERIAL_OUT_OE <= 1'h0;
    end else begin
      TEST_SERIAL_OUT <= tdo_bit;
      TEST_SERIAL_OUT_OE <= in_shift;
    end
  end

  // Mode levels into the system domain
  sync2 #(.W(2)) u_mode_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(mode_reg),
    .q(sys_mode)
  );

  // Latch word crosses by toggle; word is stable long before the toggle lands
  sync2 #(.W(1)) u_toggle_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(latch_toggle_reg),
    .q(sys_toggle)
  );

  // Copy of the output latches in the system domain
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sys_toggle_prev_reg <= 1'h0;
      sys_latch_reg <= '0;
    end else begin
      sys_toggle_prev_reg <= sys_toggle;
      if (sys_toggle != sys_toggle_prev_reg) begin
        sys_latch_reg <= bsr_latch_reg;
      end
    end
  end

  // Pad drivers: high-Z wins, then boundary latches, else normal framer
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PAD_OUT <= '0;
      PAD_OE <= '0;
    end else if (sys_mode.force_hiz) begin
      PAD_OUT <= CORE_OUT;
      PAD_OE <= '0;
    end else if (sys_mode.drive_bsr) begin
      PAD_OUT <= sys_latch_reg[N_OUT-1:0];
      PAD_OE <= sys_latch_reg[LAT_LEN-1:N_OUT];
    end else begin
      PAD_OUT <= CORE_OUT;
      PAD_OE <= CORE_OE;
    end
  end

  // Checks in the test clock domain
  property p_five_high_reset;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    TEST_MODE_SELECT [*5] |=> state_reg == tap_pkg::TLR;
  endproperty
  a_five_high_reset: assert property (p_five_high_reset)
    else $error("five high mode edges missed reset state");

  property p_sel_dr_to_capture;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    (state_reg == tap_pkg::SEL_DR && !TEST_MODE_SELECT) |=>
      (state_reg == tap_pkg::CAP_DR) && $stable(bsr_shift_reg);
  endproperty
  a_sel_dr_to_capture: assert property (p_sel_dr_to_capture)
    else $error("select-DR did not go to capture or moved data");

  property p_exit1_dr_update;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    (state_reg == tap_pkg::EXIT1_DR && TEST_MODE_SELECT) |=>
      state_reg == tap_pkg::UPD_DR;
  endproperty
  a_exit1_dr_update: assert property (p_exit1_dr_update)
    else $error("exit1-DR with mode high did not update");

  property p_pause_dr_hold;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    (state_reg == tap_pkg::PAUSE_DR && !TEST_MODE_SELECT) |=>
      state_reg == tap_pkg::PAUSE_DR && $stable(id_shift_reg) &&
      $stable(bypass_reg) && $stable(bsr_shift_reg);
  endproperty
  a_pause_dr_hold: assert property (p_pause_dr_hold)
    else $error("pause-DR did not hold");

  property p_capture_ir_value;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    state_reg == tap_pkg::CAP_IR |=> ir_shift_reg == `IR_CAPTURE_VAL;
  endproperty
  a_capture_ir_value: assert property (p_capture_ir_value)
    else $error("capture-IR loaded wrong value");

  property p_shift_ir_moves;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    state_reg == tap_pkg::SHIFT_IR |=>
      ir_shift_reg == {$past(TEST_SERIAL_IN), $past(ir_shift_reg[2:1])} &&
      $stable(ir_latch_reg);
  endproperty
  a_shift_ir_moves: assert property (p_shift_ir_moves)
    else $error("instruction shift stage moved wrongly");

  property p_idcode_capture;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    (state_reg == tap_pkg::CAP_DR && ir_latch_reg == `IR_IDCODE) |=>
      id_shift_reg == id_value && id_shift_reg[0];
  endproperty
  a_idcode_capture: assert property (p_idcode_capture)
    else $error("identification not captured");

  property p_bypass_path;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    (state_reg == tap_pkg::SHIFT_DR && dr_sel == tap_pkg::DR_BYPASS) |=>
      bypass_reg == $past(TEST_SERIAL_IN);
  endproperty
  a_bypass_path: assert property (p_bypass_path)
    else $error("bypass stage did not take serial in");

  property p_reset_loads_idcode;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    state_reg == tap_pkg::TLR ##1 state_reg == tap_pkg::TLR |->
      ir_latch_reg == `IR_IDCODE;
  endproperty
  a_reset_loads_idcode: assert property (p_reset_loads_idcode)
    else $error("reset state did not force IDCODE");

  // Enable is launched a half period early, so it matches the sampled state
  property p_tdo_enable;
    @(posedge TEST_CLOCK_IN) disable iff (!TEST_RESET_N)
    TEST_SERIAL_OUT_OE == ((state_reg == tap_pkg::SHIFT_DR) ||
                           (state_reg == tap_pkg::SHIFT_IR));
  endproperty
  a_tdo_enable: assert property (p_tdo_enable)
    else $error("serial out enable outside shift states");

  // System side: high-Z mode floats every pad on the next system clock cycle
  property p_highz_pads;
    @(posedge SYS_CLK) disable iff (!RST_N)
    sys_mode.force_hiz |=> PAD_OE == '0;
  endproperty
  a_highz_pads: assert property (p_highz_pads)
    else $error("pads driven under high-Z");

  c_idcode_scan: cover property (@(posedge TEST_CLOCK_IN)
    state_reg == tap_pkg::CAP_DR && dr_sel == tap_pkg::DR_ID);
  c_update_ir: cover property (@(posedge TEST_CLOCK_IN)
    state_reg == tap_pkg::UPD_IR);
  c_pause_ir_loop: cover property (@(posedge TEST_CLOCK_IN)
    state_reg == tap_pkg::EXIT2_IR && !TEST_MODE_SELECT);
  c_extest_drive: cover property (@(posedge SYS_CLK)
    sys_mode.drive_bsr);

endmodule
`default_nettype wire

// ===== testbench/scan_tester.sv
// Behavioural boundary-scan tester that drives the test port
`default_nettype none
module scan_tester #(
  parameter realtime HALF = 62.5 // Half of the 125 ns test clock period
) (
  output logic tck, // Test clock, still between frames
  output logic tms, // Mode select
  output logic tdi, // Serial data towards the port
  input wire logic tdo // Serial data from the port
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock; data out is read just before the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(HALF);
    q = tdo;
    tck = 1'b1;
    #(HALF);
    tck = 1'b0;
  endtask

  // Reset without the reset pin, then park in Run-Test-Idle
  task automatic go_reset();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask

  // Full scan from Run-Test-Idle back to Run-Test-Idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) begin
      step(1'b1, ~tdi, q);
    end
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    // Idle data line keeps changing so a stale level is never trusted
    tdi = ~tdi;
  endtask

  // Same scan, but it rests in the pause state after the middle bit
  task automatic scan_pause(input logic ir, input int n,
                            input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) begin
      step(1'b1, ~tdi, q);
    end
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n / 2 || i == n - 1, din[i], q);
      dout[i] = q;
      if (i == n / 2) begin
        step(1'b0, ~tdi, q); // Exit1 to pause
        step(1'b0, ~tdi, q); // Pause stays put
        step(1'b1, ~tdi, q); // Pause to exit2
        step(1'b0, ~tdi, q); // Exit2 back to shift
      end
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    tdi = ~tdi;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_boundary_scan_tap.sv
// Self-checking bench for the boundary-scan test access port
`default_nettype none
module tb_boundary_scan_tap;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [10:0] MANUF = 11'h2b3; // Arbitrary value
  localparam logic [15:0] PART = 16'h5a17; // Arbitrary value
  localparam logic [3:0] VER = 4'h6; // Arbitrary value
  localparam logic [31:0] ID_EXP = {VER, PART, MANUF, 1'b1};
  localparam logic [11:0] PRE = 12'ha63; // Enables, data, input cells

  logic sys_clk, rst_n, trst_n, tdo_q, tdo_oe;
  logic [3:0] core_out, core_oe, pad_in, pad_out, pad_oe;
  wire tck, tms, tdi, tdo_line;
  int n_errors = 0;
  int cmp_count = 0;

  // Serial out only reaches the tester while enabled
  assign tdo_line = tdo_oe ? tdo_q : 1'bz;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  tap_top #(.MANUF_ID(MANUF), .PART_ID(PART), .VERSION_ID(VER)) i_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .TEST_CLOCK_IN(tck),
    .TEST_RESET_N(trst_n), .TEST_MODE_SELECT(tms), .TEST_SERIAL_IN(tdi),
    .TEST_SERIAL_OUT(tdo_q), .TEST_SERIAL_OUT_OE(tdo_oe),
    .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe)
  );

  scan_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Let pad control cross into the system domain
  task automatic sys_wait(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset_id();
    logic [31:0] d;
    i_tester.scan(1'b0, 32, 32'h0, d);
    chk("id", ID_EXP, d);
    chk("tdo_oe idle", 32'h0, {31'h0, tdo_oe});
    chk("pad_out", {28'h0, core_out}, {28'h0, pad_out});
  endtask

  // All bypass codes, including the unassigned ones
  task automatic t_bypass();
    logic [31:0] d;
    logic [2:0] codes [5] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h6};
    foreach (codes[k]) begin
      i_tester.scan(1'b1, 3, {29'h0, codes[k]}, d);
      chk("ir capture", 32'h1, {29'h0, d[2:0]});
      i_tester.scan(1'b0, 4, 32'hb, d);
      chk("bypass path", 32'h6, {28'h0, d[3:0]});
    end
  endtask

  task automatic t_sample_extest();
    logic [31:0] d;
    i_tester.scan(1'b1, 3, 32'h2, d);
    i_tester.scan(1'b0, 12, {20'h0, PRE}, d);
    chk("sample", {20'h0, core_oe, core_out, pad_in}, d);
    chk("pads untouched", {28'h0, core_oe}, {28'h0, pad_oe});
    i_tester.scan(1'b1, 3, 32'h0, d);
    sys_wait(10);
    chk("extest out", {28'h0, PRE[7:4]}, {28'h0, pad_out});
    chk("extest oe", {28'h0, PRE[11:8]}, {28'h0, pad_oe});
    pad_in = 4'ha;
    i_tester.scan(1'b0, 12, {20'h0, PRE}, d);
    chk("extest capture", 32'ha, {28'h0, d[3:0]});
  endtask

  task automatic t_clamp_highz();
    logic [31:0] d;
    i_tester.scan(1'b1, 3, 32'h3, d);
    sys_wait(1);
    core_out = 4'h3;
    sys_wait(10);
    chk("clamp out", {28'h0, PRE[7:4]}, {28'h0, pad_out});
    chk("clamp oe", {28'h0, PRE[11:8]}, {28'h0, pad_oe});
    i_tester.scan(1'b1, 3, 32'h4, d);
    sys_wait(10);
    chk("highz oe", 32'h0, {28'h0, pad_oe});
  endtask

  // Mode select alone must restore normal pads and the identity scan
  task automatic t_tms_reset();
    logic [31:0] d;
    i_tester.go_reset();
    sys_wait(10);
    chk("reset out", {28'h0, core_out}, {28'h0, pad_out});
    chk("reset oe", {28'h0, core_oe}, {28'h0, pad_oe});
    i_tester.scan(1'b0, 32, 32'h0, d);
    chk("id again", ID_EXP, d);
  endtask

  // Resting in both pause states must neither shift nor lose a bit
  task automatic t_pause();
    logic [31:0] d, e;
    i_tester.scan_pause(1'b1, 3, 32'h2, d);
    chk("paused ir capture", 32'h1, {29'h0, d[2:0]});
    e = {20'h0, core_oe, core_out, pad_in};
    i_tester.scan_pause(1'b0, 12, {20'h0, PRE}, d);
    chk("paused dr", e, d);
  endtask

  // The test reset pin alone must also bring the pads back to normal
  task automatic t_trst();
    logic [31:0] d;
    i_tester.scan(1'b1, 3, 32'h4, d);
    sys_wait(10);
    chk("trst hiz", 32'h0, {28'h0, pad_oe});
    trst_n = 1'b0;
    sys_wait(2);
    trst_n = 1'b1;
    sys_wait(10);
    chk("trst oe", {28'h0, core_oe}, {28'h0, pad_oe});
    i_tester.go_reset();
    i_tester.scan(1'b0, 32, 32'h0, d);
    chk("id after trst", ID_EXP, d);
  endtask

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    trst_n = 1'b0;
    core_out = 4'h9;
    core_oe = 4'hc;
    pad_in = 4'h5;
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    trst_n = 1'b1;
    sys_wait(4);
    i_tester.go_reset();
    t_reset_id();
    t_bypass();
    t_sample_extest();
    t_clamp_highz();
    t_tms_reset();
    t_pause();
    t_trst();
    test_done();
  end
endmodule
`default_nettype wire
